// ---- call_clear_complement_ops_tb_top.sv ----
// self-checking bench for the call/clear/complement executor
// assumes one clock; results stand one cycle after the op
`timescale 1ns/1ps
`default_nettype none
module call_clear_complement_ops_tb_top
  import cco_pkg::*;
;
  typedef struct packed {
    logic [3:0] strb;
    logic [PC_W-1:0] sd;
    logic [PC_W-1:0] pd;
    logic [MADDR_W-1:0] a;
    logic [DATA_W-1:0] wd;
    cco_flags_type f;
  } cco_exp_type;
  logic I_CLK, I_ARST_N, I_OP_VALID, I_TO_SET, I_PDF_SET, I_ALU_FLAG_WE;
  cco_instr_type I_INSTR;
  cco_flags_type I_ALU_FLAGS, O_FLAGS;
  logic [PC_W-1:0] I_PC, O_STACK_DATA, O_PC_DATA;
  logic O_STACK_PUSH, O_PC_LOAD, O_MEM_WE, O_WDT_CLEAR, took, fst, sec;
  logic [MADDR_W-1:0] O_MEM_ADDR;
  logic [DATA_W-1:0] O_MEM_WDATA;
  wire logic [DATA_W-1:0] mem_rd;
  wire logic [3:0] strb_seen;
  assign strb_seen = {O_STACK_PUSH, O_PC_LOAD, O_MEM_WE, O_WDT_CLEAR};
  cco_exp_type e, x, exp_q[$];
  int err_total, n_tests;
  cco_exec DUT (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_OP_VALID(I_OP_VALID),
    .I_INSTR(I_INSTR), .I_PC(I_PC), .I_MEM_RDATA(mem_rd), .I_TO_SET(I_TO_SET),
    .I_PDF_SET(I_PDF_SET), .I_ALU_FLAG_WE(I_ALU_FLAG_WE), .I_ALU_FLAGS(I_ALU_FLAGS),
    .O_STACK_PUSH(O_STACK_PUSH), .O_STACK_DATA(O_STACK_DATA), .O_PC_LOAD(O_PC_LOAD),
    .O_PC_DATA(O_PC_DATA), .O_MEM_WE(O_MEM_WE), .O_MEM_ADDR(O_MEM_ADDR),
    .O_MEM_WDATA(O_MEM_WDATA), .O_WDT_CLEAR(O_WDT_CLEAR), .O_FLAGS(O_FLAGS));
  cco_mem_model mem (.i_clk(I_CLK), .i_addr(I_INSTR.maddr), .i_we(O_MEM_WE),
    .i_waddr(O_MEM_ADDR), .i_wdata(O_MEM_WDATA), .o_rdata(mem_rd));
  // ****************
  // tasks
  // ****************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  // one cycle of stimulus; the expectation is noted before the result shows
  task automatic do_op(input logic v, input cco_op_type op);
    logic clr;
    @(posedge I_CLK);
    #1;
    I_OP_VALID = v;
    I_INSTR = '{op: op, target: PC_W'($urandom), maddr: MADDR_W'($urandom),
                bit_sel: BIT_W'($urandom)};
    I_PC = PC_W'($urandom);
    I_TO_SET = ($urandom % 8 == 0);
    I_PDF_SET = ($urandom % 8 == 0);
    I_ALU_FLAG_WE = 1'($urandom % 2);
    I_ALU_FLAGS = 6'($urandom);
    #1;
    e.strb = 4'h0;
    clr = 1'b0;
    if (v) begin
      case (op)
        OP_CALL: begin
          e.strb = 4'b1100;
          e.sd = I_PC + PC_STEP;
          e.pd = I_INSTR.target;
        end
        OP_BYTE_ZERO, OP_BIT_ZERO, OP_BYTE_INVERT: begin
          e.strb = 4'b0010;
          e.a = I_INSTR.maddr;
          e.wd = (op == OP_BYTE_ZERO) ? BYTE_ZERO :
                 (op == OP_BYTE_INVERT) ? ~mem_rd : mem_rd & ~(BIT_ONE << I_INSTR.bit_sel);
        end
        OP_WATCHDOG_SINGLE_CLEAR: clr = 1'b1;
        OP_WATCHDOG_PRECLEAR_FIRST: if (sec) clr = 1'b1; else fst = 1'b1;
        OP_WATCHDOG_PRECLEAR_SECOND: if (fst) clr = 1'b1; else sec = 1'b1;
        default: ;
      endcase
    end
    if (clr && op != OP_WATCHDOG_SINGLE_CLEAR) {fst, sec} = 2'b00;
    if (clr) {e.strb[0], e.f.time_out_flag, e.f.power_down_flag} = 3'b100;
    if (I_TO_SET) e.f.time_out_flag = 1'b1;
    if (I_PDF_SET) e.f.power_down_flag = 1'b1;
    if (I_ALU_FLAG_WE && !(v && op inside {OP_CALL, OP_BYTE_ZERO, OP_BIT_ZERO}))
      e.f[3:0] = I_ALU_FLAGS[3:0];
    if (v) exp_q.push_back(e);
  endtask : do_op
  // ****************
  // clock, monitor, watchdog
  // ****************
  initial begin
    I_CLK = 1'b0;
    forever #20 I_CLK = ~I_CLK;
  end
  always @(posedge I_CLK) took <= I_OP_VALID && I_ARST_N;
  always @(negedge I_CLK) begin
    if (took && exp_q.size() > 0) begin
      x = exp_q.pop_front();
      chk("strobes", 16'(strb_seen), 16'(x.strb));
      chk("stack data", 16'(O_STACK_DATA), 16'(x.sd));
      chk("pc data", 16'(O_PC_DATA), 16'(x.pd));
      chk("mem addr", 16'(O_MEM_ADDR), 16'(x.a));
      chk("mem data", 16'(O_MEM_WDATA), 16'(x.wd));
      chk("flags", 16'(O_FLAGS), 16'(x.f));
    end
  end
  initial begin
    repeat (4000) @(posedge I_CLK);
    err_total++;
    close_out();
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    {I_ARST_N, I_OP_VALID, I_TO_SET, I_PDF_SET, I_ALU_FLAG_WE, fst, sec} = '0;
    I_INSTR = '0;
    I_PC = '0;
    I_ALU_FLAGS = '0;
    e = '0;
    err_total = 0;
    n_tests = 0;
    void'($urandom(32'h39bb6f09));
    repeat (20) @(posedge I_CLK);
    #1 I_ARST_N = 1'b1;
    for (int k = 0; k < 8; k++) do_op(1'b1, cco_op_type'(k));
    // lone second preclear, repeated, other ops between, then the partner
    do_op(1'b1, OP_WATCHDOG_PRECLEAR_SECOND);
    do_op(1'b1, OP_BYTE_ZERO);
    do_op(1'b1, OP_WATCHDOG_PRECLEAR_SECOND);
    do_op(1'b0, OP_NONE);
    do_op(1'b1, OP_WATCHDOG_PRECLEAR_FIRST);
    for (int k = 0; k < 800; k++) do_op($urandom % 4 != 0, cco_op_type'($urandom % 8));
    do_op(1'b0, OP_NONE);
    repeat (3) @(posedge I_CLK);
    close_out();
  end
endmodule : call_clear_complement_ops_tb_top
`default_nettype wire

// ---- cco_exec.sv ----
// executor for call, clears, watchdog clears and byte invert
// assumes memory read data for the addressed byte is valid with the op strobe
`timescale 1ns/1ps
`default_nettype none
module cco_exec
  import cco_pkg::*;
(
  input  wire logic                I_CLK,
  input  wire logic                I_ARST_N,
  input  wire logic                I_OP_VALID,
  input  wire cco_instr_type       I_INSTR,
  input  wire logic [PC_W-1:0]     I_PC,
  input  wire logic [DATA_W-1:0]   I_MEM_RDATA,
  input  wire logic                I_TO_SET,
  input  wire logic                I_PDF_SET,
  input  wire logic                I_ALU_FLAG_WE,
  input  wire cco_flags_type       I_ALU_FLAGS,
  output var  logic                O_STACK_PUSH,
  output var  logic [PC_W-1:0]     O_STACK_DATA,
  output var  logic                O_PC_LOAD,
  output var  logic [PC_W-1:0]     O_PC_DATA,
  output var  logic                O_MEM_WE,
  output var  logic [MADDR_W-1:0]  O_MEM_ADDR,
  output var  logic [DATA_W-1:0]   O_MEM_WDATA,
  output var  logic                O_WDT_CLEAR,
  output var  cco_flags_type       O_FLAGS
);

  logic           act_call;
  logic           act_bzero;
  logic           act_bitz;
  logic           act_single;
  logic           act_first;
  logic           act_second;
  logic           act_inv;
  logic           pair_done;
  logic           wdt_clr;
  logic [DATA_W-1:0] bit_mask;

  // ****************
  // decode
  // ****************
  assign act_call   = I_OP_VALID && (I_INSTR.op == OP_CALL);
  assign act_bzero  = I_OP_VALID && (I_INSTR.op == OP_BYTE_ZERO);
  assign act_bitz   = I_OP_VALID && (I_INSTR.op == OP_BIT_ZERO);
  assign act_single = I_OP_VALID && (I_INSTR.op == OP_WATCHDOG_SINGLE_CLEAR);
  assign act_first  = I_OP_VALID && (I_INSTR.op == OP_WATCHDOG_PRECLEAR_FIRST);
  assign act_second = I_OP_VALID && (I_INSTR.op == OP_WATCHDOG_PRECLEAR_SECOND);
  assign act_inv    = I_OP_VALID && (I_INSTR.op == OP_BYTE_INVERT);
  assign bit_mask   = BIT_ONE << I_INSTR.bit_sel;

  cco_preclear u_preclear (
    .i_clk       (I_CLK),
    .i_arst_n    (I_ARST_N),
    .i_first     (act_first),
    .i_second    (act_second),
    .o_pair_done (pair_done)
  );

  assign wdt_clr = act_single | pair_done;

  // ****************
  // call: push and load issued together, stack takes the push first
  // ****************
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_STACK_PUSH <= 1'b0;
      O_STACK_DATA <= PC_RST;
      O_PC_LOAD    <= 1'b0;
      O_PC_DATA    <= PC_RST;
    end else begin
      O_STACK_PUSH <= act_call;
      O_PC_LOAD    <= act_call;
      if (act_call) begin
        O_STACK_DATA <= I_PC + PC_STEP;
        O_PC_DATA    <= I_INSTR.target;
      end
    end
  end

  // ****************
  // data memory write-back
  // ****************
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_MEM_WE    <= 1'b0;
      O_MEM_ADDR  <= MADDR_RST;
      O_MEM_WDATA <= BYTE_ZERO;
    end else begin
      O_MEM_WE <= act_bzero | act_bitz | act_inv;
      if (act_bzero | act_bitz | act_inv) begin
        O_MEM_ADDR <= I_INSTR.maddr;
      end
      if (act_bzero) begin
        O_MEM_WDATA <= BYTE_ZERO;
      end else if (act_bitz) begin
        O_MEM_WDATA <= I_MEM_RDATA & ~bit_mask;
      end else if (act_inv) begin
        O_MEM_WDATA <= I_MEM_RDATA ^ BYTE_ONES;
      end
    end
  end

  // ****************
  // watchdog clear strobe and status flags
  // ****************
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_WDT_CLEAR <= 1'b0;
    end else begin
      O_WDT_CLEAR <= wdt_clr;
    end
  end

  // set events win over a clear in the same cycle
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_FLAGS <= FLAGS_RST;
    end else begin
      if (I_TO_SET) begin
        O_FLAGS.time_out_flag <= 1'b1;
      end else if (wdt_clr) begin
        O_FLAGS.time_out_flag <= 1'b0;
      end
      if (I_PDF_SET) begin
        O_FLAGS.power_down_flag <= 1'b1;
      end else if (wdt_clr) begin
        O_FLAGS.power_down_flag <= 1'b0;
      end
      // arithmetic flags move for any op except call, byte zero and bit zero
      if (I_ALU_FLAG_WE && !(act_call | act_bzero | act_bitz)) begin
        O_FLAGS.overflow_flag  <= I_ALU_FLAGS.overflow_flag;
        O_FLAGS.zero_flag      <= I_ALU_FLAGS.zero_flag;
        O_FLAGS.aux_carry_flag <= I_ALU_FLAGS.aux_carry_flag;
        O_FLAGS.carry_flag     <= I_ALU_FLAGS.carry_flag;
      end
    end
  end

  // ****************
  // assertions
  // ****************
  call_push_addr_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    act_call |=> O_STACK_PUSH && O_STACK_DATA == $past(I_PC) + PC_STEP)
    else $error("call pushed wrong return address");

  call_target_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    act_call |=> O_PC_LOAD && O_PC_DATA == $past(I_INSTR.target))
    else $error("call did not load target");

  call_push_load_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    O_PC_LOAD |-> O_STACK_PUSH)
    else $error("program counter loaded without push");

  byte_zero_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    act_bzero |=> O_MEM_WE && O_MEM_WDATA == BYTE_ZERO)
    else $error("byte zero wrote nonzero");

  bit_zero_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    act_bitz |=> O_MEM_WE && !O_MEM_WDATA[$past(I_INSTR.bit_sel)]
      && ((O_MEM_WDATA ^ $past(I_MEM_RDATA)) & ~$past(bit_mask)) == BYTE_ZERO)
    else $error("bit zero disturbed other bits");

  byte_invert_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    act_inv |=> O_MEM_WE && (O_MEM_WDATA ^ $past(I_MEM_RDATA)) == BYTE_ONES
      && O_MEM_ADDR == $past(I_INSTR.maddr))
    else $error("byte invert result wrong");

  mem_addr_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (act_bzero || act_bitz || act_inv) |=> O_MEM_WE && O_MEM_ADDR == $past(I_INSTR.maddr))
    else $error("write-back went to the wrong address");

  single_clear_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (act_single && !I_TO_SET && !I_PDF_SET) |=> O_WDT_CLEAR
      && !O_FLAGS.time_out_flag && !O_FLAGS.power_down_flag)
    else $error("single clear missed counter or flags");

  // a preclear that itself closed a pair leaves nothing behind to pair with
  pair_clear_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (((act_second && $past(act_first)) || (act_first && $past(act_second)))
      && !$past(pair_done)) |=> O_WDT_CLEAR)
    else $error("preclear pair did not clear");

  pair_flags_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (pair_done && !I_TO_SET && !I_PDF_SET) |=> O_WDT_CLEAR
      && !O_FLAGS.time_out_flag && !O_FLAGS.power_down_flag)
    else $error("preclear pair left a status flag set");

  lone_hold_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (O_WDT_CLEAR) |-> $past(act_single || pair_done))
    else $error("watchdog cleared without a complete clear");

  lone_flags_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    ((act_first || act_second) && !pair_done && !I_TO_SET && !I_PDF_SET)
      |=> !O_WDT_CLEAR && $stable(O_FLAGS[5:4]))
    else $error("lone preclear touched counter or flags");

  arith_hold_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (act_call || act_bzero || act_bitz) |=> $stable(O_FLAGS[3:0]))
    else $error("arithmetic flags changed");

  arith_load_a: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (I_ALU_FLAG_WE && !(act_call || act_bzero || act_bitz))
      |=> O_FLAGS[3:0] == $past(I_ALU_FLAGS[3:0]))
    else $error("arithmetic flags not loaded");

  // main scenarios
  call_seen_c: cover property (@(posedge I_CLK) disable iff (!I_ARST_N) act_call);
  pair_seen_c: cover property (@(posedge I_CLK) disable iff (!I_ARST_N)
    act_second ##[1:4] act_first ##1 O_WDT_CLEAR);
  invert_seen_c: cover property (@(posedge I_CLK) disable iff (!I_ARST_N)
    act_inv ##1 O_MEM_WE);
  lone_seen_c: cover property (@(posedge I_CLK) disable iff (!I_ARST_N)
    act_second && !pair_done);
  bitz_seen_c: cover property (@(posedge I_CLK) disable iff (!I_ARST_N)
    act_bitz ##1 O_MEM_WE);

endmodule : cco_exec
`default_nettype wire

// ---- cco_mem_model.sv ----
// data memory model facing the executor's memory port
// assumes write strobe, address and data are registered by the executor
`timescale 1ns/1ps
`default_nettype none
module cco_mem_model
  import cco_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic [MADDR_W-1:0] i_addr,
  input  wire logic               i_we,
  input  wire logic [MADDR_W-1:0] i_waddr,
  input  wire logic [DATA_W-1:0]  i_wdata,
  output var  logic [DATA_W-1:0]  o_rdata
);
  logic [DATA_W-1:0] mem_q [2**MADDR_W];
  initial for (int k = 0; k < 2**MADDR_W; k++) mem_q[k] = DATA_W'(k * 37 + 5);
  // read is combinational: the executor has no read cycle
  assign o_rdata = mem_q[i_addr];
  always @(posedge i_clk) if (i_we) mem_q[i_waddr] <= i_wdata;
endmodule : cco_mem_model
`default_nettype wire

// ---- cco_pkg.sv ----
// constants and types shared by the call/clear/complement executor
// assumes one core clock; all callers sit on the same clock domain
//
// Functional notes
// - a call always transfers control to the target address held in the instruction.
// - a call first pushes the return address, the current program counter plus one.
// - after the push, a call loads the program counter with the target address.
// - byte zero writes zero to every bit of the addressed data byte.
// - bit zero clears only the selected bit of the addressed byte and keeps the rest.
// - the single watchdog clear resets the watchdog counter to zero.
// - the single watchdog clear also drives the power-down and time-out flags to zero, except a flag whose set event comes in the same cycle.
// - the first preclear clears the watchdog only together with the second preclear.
// - the second preclear clears only together with the first; the pair clears both flags, except a flag whose set event comes in the same cycle.
// - byte invert flips every bit of the addressed byte and writes it back in place.
package cco_pkg;

  // ****************
  // widths and values
  // ****************
  localparam int unsigned PC_W    = 10;
  localparam int unsigned MADDR_W = 6;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned BIT_W   = 3;

  localparam logic [PC_W-1:0]    PC_STEP     = 10'h001;
  localparam logic [PC_W-1:0]    PC_RST      = 10'h000;
  localparam logic [MADDR_W-1:0] MADDR_RST   = 6'h00;
  localparam logic [DATA_W-1:0]  BYTE_ZERO   = 8'h00;
  localparam logic [DATA_W-1:0]  BYTE_ONES   = 8'hff;
  localparam logic [DATA_W-1:0]  BIT_ONE     = 8'h01;

  // ****************
  // types
  // ****************
  typedef enum logic [2:0] {
    OP_NONE,
    OP_CALL,
    OP_BYTE_ZERO,
    OP_BIT_ZERO,
    OP_WATCHDOG_SINGLE_CLEAR,
    OP_WATCHDOG_PRECLEAR_FIRST,
    OP_WATCHDOG_PRECLEAR_SECOND,
    OP_BYTE_INVERT
  } cco_op_type;

  typedef struct packed {
    logic time_out_flag;
    logic power_down_flag;
    logic overflow_flag;
    logic zero_flag;
    logic aux_carry_flag;
    logic carry_flag;
  } cco_flags_type;

  localparam cco_flags_type FLAGS_RST = 6'h00;

  typedef struct packed {
    cco_op_type          op;
    logic [PC_W-1:0]     target;
    logic [MADDR_W-1:0]  maddr;
    logic [BIT_W-1:0]    bit_sel;
  } cco_instr_type;

endpackage : cco_pkg

// ---- cco_preclear.sv ----
// two-step watchdog clear pairing tracker
// assumes op strobes come from core logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module cco_preclear
  import cco_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_first,
  input  wire logic i_second,
  output var  logic o_pair_done
);

  logic first_seen_q;
  logic second_seen_q;

  // pair completes when the partner has already been recorded
  assign o_pair_done = (i_first & second_seen_q) | (i_second & first_seen_q);

  // ****************
  // record lone executions, drop both once paired
  // ****************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      first_seen_q  <= 1'b0;
      second_seen_q <= 1'b0;
    end else if (o_pair_done) begin
      first_seen_q  <= 1'b0;
      second_seen_q <= 1'b0;
    end else begin
      if (i_first) begin
        first_seen_q <= 1'b1;
      end
      if (i_second) begin
        second_seen_q <= 1'b1;
      end
    end
  end

  lone_no_pair_a: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_first && !second_seen_q) |-> !o_pair_done ##1 first_seen_q)
    else $error("lone first preclear not recorded or paired");

endmodule : cco_preclear
`default_nettype wire
